// ### rtl/wra_pkg.sv
package wra_pkg;

   localparam int unsigned REG_W      = 16;
   localparam int unsigned REG_CNT    = 16;
   localparam int unsigned IDX_W      = 4;

   // fixed register roles
   localparam logic [3:0] IDX_DEFAULT   = 4'h0;
   localparam logic [3:0] IDX_QUOTIENT  = 4'h0;
   localparam logic [3:0] IDX_REMAINDER = 4'h1;
   localparam logic [3:0] IDX_PROD_LOW  = 4'h2;
   localparam logic [3:0] IDX_PROD_HIGH = 4'h3;
   localparam logic [3:0] IDX_MAC_OP0   = 4'h4;
   localparam logic [3:0] IDX_XPTR0     = 4'h8;
   localparam logic [3:0] IDX_XPTR1     = 4'h9;
   localparam logic [3:0] IDX_YPTR0     = 4'ha;
   localparam logic [3:0] IDX_YPTR1     = 4'hb;
   localparam logic [3:0] IDX_PF_OFFSET = 4'hc;
   localparam logic [3:0] IDX_WB_DEST   = 4'hd;
   localparam logic [3:0] IDX_FRAME_PTR = 4'he;
   localparam logic [3:0] IDX_STACK_PTR = 4'hf;

   localparam logic [15:0] REG_RESET    = 16'h0000;

   typedef enum logic [3:0] {
      WRA_OP_NONE,
      WRA_OP_WRITE,      // generic write, any register
      WRA_OP_FILE_WR,    // file-register op result into default register
      WRA_OP_MOVF_WR,    // move from file into a working register
      WRA_OP_DIV,        // quotient and remainder
      WRA_OP_MULF_WORD,  // legacy file multiply, word mode
      WRA_OP_MULF_BYTE,  // legacy file multiply, byte mode
      WRA_OP_MUL_PAIR,   // 17x17 multiplier result to even pair
      WRA_OP_MAC_WB,     // prefetching dsp class write-back
      WRA_OP_FRAME,      // link / unlink frame pointer update
      WRA_OP_STACK       // stack pointer update
   } wra_op_t;

   typedef struct packed {
      wra_op_t     op;
      logic        byte_mode;
      logic [3:0]  dst;
      logic [15:0] data_lo;
      logic [15:0] data_hi;
   } wra_wr_t;

   typedef struct packed {
      logic [15:0] op0;
      logic [15:0] op1;
      logic [15:0] op2;
      logic [15:0] op3;
   } wra_mac_ops_t;

   typedef struct packed {
      logic [15:0] x0;
      logic [15:0] x1;
      logic [15:0] y0;
      logic [15:0] y1;
      logic [15:0] offset;
   } wra_pf_t;

endpackage : wra_pkg

// ### rtl/wra_byte_merge.sv
`timescale 1ns/1ps
module wra_byte_merge (
   // inputs
   input  wire logic [15:0] old_val,
   input  wire logic [15:0] new_val,
   input  wire logic        byte_mode,
   // result
   output logic      [15:0] merged
);
   always_comb begin
      if (byte_mode) begin
         merged = {old_val[15:8], new_val[7:0]};
      end else begin
         merged = new_val;
      end
   end
endmodule : wra_byte_merge

// ### rtl/wra_legacy_mul.sv
`timescale 1ns/1ps
module wra_legacy_mul (
   // operands
   input  wire logic [15:0] file_val,
   input  wire logic [15:0] dflt_val,
   input  wire logic        byte_mode,
   // product
   output logic      [31:0] product
);
   always_comb begin
      if (byte_mode) begin
         // widen the bytes first so the 16-bit product is not cut to 8 bits
         product = {16'h0000, {8'h00, file_val[7:0]} * {8'h00, dflt_val[7:0]}};
      end else begin
         product = {16'h0000, file_val} * {16'h0000, dflt_val};
      end
   end
endmodule : wra_legacy_mul

// ### rtl/wra_regfile.sv
`timescale 1ns/1ps
module wra_regfile (
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  rstn,
   input  wire logic                  clk_en,
   // write request
   input  wire wra_pkg::wra_wr_t      wr,
   input  wire logic [15:0]           mulf_file_val,
   // generic read ports
   input  wire logic [3:0]            rd_a_idx,
   input  wire logic [3:0]            rd_b_idx,
   output logic      [15:0]           rd_a_data,
   output logic      [15:0]           rd_b_data,
   // implied role views
   output logic      [15:0]           default_work_register,
   output wra_pkg::wra_mac_ops_t      mac_ops,
   output wra_pkg::wra_pf_t           pf_ptrs,
   output logic      [15:0]           frame_pointer_reg,
   output logic      [15:0]           stack_pointer_reg,
   // status
   output logic                       wr_reject
);

   logic [15:0] regs_r   [wra_pkg::REG_CNT];
   logic [15:0] regs_nxt [wra_pkg::REG_CNT];
   logic [15:0] rd_a_nxt;
   logic [15:0] rd_b_nxt;
   logic        reject_nxt;
   logic        mulf_byte;
   logic [15:0] merged;
   logic [31:0] mulf_prod;
   logic [3:0]  pair_hi;
   logic [3:0]  gen_dst;

   // the merge target is the write target: the default register for file ops, wr.dst otherwise
   wra_byte_merge u_merge (
      .old_val   (regs_r[gen_dst]),
      .new_val   (wr.data_lo),
      .byte_mode (wr.byte_mode),
      .merged    (merged)
   );

   // the op, not the byte flag, picks the multiply width
   assign mulf_byte = (wr.op == wra_pkg::WRA_OP_MULF_BYTE);

   wra_legacy_mul u_mul (
      .file_val  (mulf_file_val),
      .dflt_val  (regs_r[wra_pkg::IDX_DEFAULT]),
      .byte_mode (mulf_byte),
      .product   (mulf_prod)
   );

   always_comb begin
      case (wr.op)
         wra_pkg::WRA_OP_FILE_WR: gen_dst = wra_pkg::IDX_DEFAULT;
         default:                 gen_dst = wr.dst;
      endcase
   end

   assign pair_hi = {wr.dst[3:1], 1'b1};

   always_comb begin
      for (int i = 0; i < wra_pkg::REG_CNT; i++) begin
         regs_nxt[i] = regs_r[i];
      end
      reject_nxt = 1'b0;
      case (wr.op)
         wra_pkg::WRA_OP_NONE: begin
         end
         wra_pkg::WRA_OP_WRITE: begin
            // any register, 14 and 15 included
            regs_nxt[wr.dst] = merged;
         end
         wra_pkg::WRA_OP_FILE_WR: begin
            regs_nxt[wra_pkg::IDX_DEFAULT] = merged;
         end
         wra_pkg::WRA_OP_MOVF_WR: begin
            if (wr.byte_mode && wr.dst != wra_pkg::IDX_DEFAULT) begin
               reject_nxt = 1'b1;
            end else begin
               regs_nxt[wr.dst] = merged;
            end
         end
         wra_pkg::WRA_OP_DIV: begin
            regs_nxt[wra_pkg::IDX_QUOTIENT]  = wr.data_lo;
            regs_nxt[wra_pkg::IDX_REMAINDER] = wr.data_hi;
         end
         wra_pkg::WRA_OP_MULF_WORD: begin
            regs_nxt[wra_pkg::IDX_PROD_LOW]  = mulf_prod[15:0];
            regs_nxt[wra_pkg::IDX_PROD_HIGH] = mulf_prod[31:16];
         end
         wra_pkg::WRA_OP_MULF_BYTE: begin
            regs_nxt[wra_pkg::IDX_PROD_LOW] = mulf_prod[15:0];
         end
         wra_pkg::WRA_OP_MUL_PAIR: begin
            // odd destination is forced down to its even partner
            regs_nxt[{wr.dst[3:1], 1'b0}] = wr.data_lo;
            regs_nxt[pair_hi]             = wr.data_hi;
         end
         wra_pkg::WRA_OP_MAC_WB: begin
            regs_nxt[wra_pkg::IDX_WB_DEST] = wr.data_lo;
         end
         wra_pkg::WRA_OP_FRAME: begin
            regs_nxt[wra_pkg::IDX_FRAME_PTR] = wr.data_lo;
            regs_nxt[wra_pkg::IDX_STACK_PTR] = wr.data_hi;
         end
         wra_pkg::WRA_OP_STACK: begin
            regs_nxt[wra_pkg::IDX_STACK_PTR] = wr.data_lo;
         end
         default: begin
            reject_nxt = 1'b1;
         end
      endcase
      // reads see the old contents; no write-through bypass
      rd_a_nxt = regs_r[rd_a_idx];
      rd_b_nxt = regs_r[rd_b_idx];
   end

   genvar g;
   generate
      for (g = 0; g < wra_pkg::REG_CNT; g++) begin : g_reg
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               regs_r[g] <= wra_pkg::REG_RESET;
            end else if (clk_en) begin
               regs_r[g] <= regs_nxt[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rd_a_data             <= wra_pkg::REG_RESET;
         rd_b_data             <= wra_pkg::REG_RESET;
         default_work_register <= wra_pkg::REG_RESET;
         mac_ops               <= '0;
         pf_ptrs               <= '0;
         frame_pointer_reg     <= wra_pkg::REG_RESET;
         stack_pointer_reg     <= wra_pkg::REG_RESET;
         wr_reject             <= 1'b0;
      end else if (clk_en) begin
         rd_a_data             <= rd_a_nxt;
         rd_b_data             <= rd_b_nxt;
         default_work_register <= regs_nxt[wra_pkg::IDX_DEFAULT];
         mac_ops.op0           <= regs_nxt[wra_pkg::IDX_MAC_OP0];
         mac_ops.op1           <= regs_nxt[wra_pkg::IDX_MAC_OP0 + 4'h1];
         mac_ops.op2           <= regs_nxt[wra_pkg::IDX_MAC_OP0 + 4'h2];
         mac_ops.op3           <= regs_nxt[wra_pkg::IDX_MAC_OP0 + 4'h3];
         pf_ptrs.x0            <= regs_nxt[wra_pkg::IDX_XPTR0];
         pf_ptrs.x1            <= regs_nxt[wra_pkg::IDX_XPTR1];
         pf_ptrs.y0            <= regs_nxt[wra_pkg::IDX_YPTR0];
         pf_ptrs.y1            <= regs_nxt[wra_pkg::IDX_YPTR1];
         pf_ptrs.offset        <= regs_nxt[wra_pkg::IDX_PF_OFFSET];
         frame_pointer_reg     <= regs_nxt[wra_pkg::IDX_FRAME_PTR];
         stack_pointer_reg     <= regs_nxt[wra_pkg::IDX_STACK_PTR];
         wr_reject             <= reject_nxt;
      end
   end

endmodule : wra_regfile

// ### verification/wra_cpu_model.sv
`timescale 1ns/1ps
module wra_cpu_model (
   // clock
   input  wire logic        clk_sys,
   // request to the register file
   output wra_pkg::wra_wr_t wr,
   output logic [15:0]      mulf_file_val
);
   initial begin
      wr = '0;
      mulf_file_val = 16'h0000;
   end
   // one op per call, then idle: a held multiply would run again
   task automatic issue(input wra_pkg::wra_op_t o, input logic b, input logic [3:0] d,
                        input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] f);
      @(posedge clk_sys);
      wr <= '{o, b, d, lo, hi};
      mulf_file_val <= f;
      @(posedge clk_sys);
      wr.op <= wra_pkg::WRA_OP_NONE;
      wr.data_lo <= ~lo;
   endtask : issue
endmodule : wra_cpu_model

// ### verification/wra_regfile_chk.sv
`timescale 1ns/1ps
module wra_regfile_chk (
   // clock and reset
   input wire logic                  clk_sys,
   input wire logic                  rstn,
   input wire logic                  clk_en,
   // requests
   input wire wra_pkg::wra_wr_t      wr,
   input wire logic [15:0]           mulf_file_val,
   input wire logic [3:0]            rd_a_idx,
   input wire logic [3:0]            rd_b_idx,
   // views
   input wire logic [15:0]           rd_a_data,
   input wire logic [15:0]           rd_b_data,
   input wire logic [15:0]           default_work_register,
   input wire wra_pkg::wra_mac_ops_t mac_ops,
   input wire wra_pkg::wra_pf_t      pf_ptrs,
   input wire logic [15:0]           frame_pointer_reg,
   input wire logic [15:0]           stack_pointer_reg,
   input wire logic                  wr_reject
);
   wra_pkg::wra_op_t op;
   logic [15:0]      lo;
   assign op = clk_en ? wr.op : wra_pkg::WRA_OP_NONE;
   assign lo = wr.data_lo;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   quot_a: assert property (op == wra_pkg::WRA_OP_DIV
      |=> default_work_register == $past(lo)) else $error("quotient not in reg 0");
   file_wr_a: assert property (op == wra_pkg::WRA_OP_FILE_WR && !wr.byte_mode
      |=> default_work_register == $past(lo)) else $error("file op missed reg 0");
   byte_low_a: assert property (op == wra_pkg::WRA_OP_FILE_WR && wr.byte_mode
      |=> default_work_register == {$past(default_work_register[15:8]), $past(lo[7:0])})
      else $error("byte write hit upper byte");
   reject_a: assert property (op == wra_pkg::WRA_OP_MOVF_WR && wr.byte_mode && wr.dst != 0
      |=> wr_reject && $stable(default_work_register)) else $error("byte move not refused");
   frame_a: assert property (op == wra_pkg::WRA_OP_FRAME
      |=> frame_pointer_reg == $past(lo)) else $error("frame pointer wrong");
   stack_a: assert property (op == wra_pkg::WRA_OP_STACK
      |=> stack_pointer_reg == $past(lo) && $stable(frame_pointer_reg)) else $error("sp wrong");
   pair_a: assert property (op == wra_pkg::WRA_OP_MUL_PAIR && wr.dst[3:1] == 3'h7
      |=> stack_pointer_reg == $past(wr.data_hi)) else $error("pair high word wrong");
   mac_op_a: assert property (op == wra_pkg::WRA_OP_WRITE && !wr.byte_mode && wr.dst == 4
      |=> mac_ops.op0 == $past(lo)) else $error("mac operand view wrong");
   frozen_view_a: assert property (!clk_en
      |=> $stable(default_work_register) && $stable(stack_pointer_reg))
      else $error("state moved while frozen");
   c_div: cover property (op == wra_pkg::WRA_OP_DIV);
   c_mul: cover property (op == wra_pkg::WRA_OP_MULF_WORD);
   c_rej: cover property (wr_reject);
endmodule : wra_regfile_chk
bind wra_regfile wra_regfile_chk wra_regfile_chk_inst (.clk_sys, .rstn, .clk_en, .wr,
   .mulf_file_val, .rd_a_idx, .rd_b_idx, .rd_a_data, .rd_b_data, .default_work_register,
   .mac_ops, .pf_ptrs, .frame_pointer_reg, .stack_pointer_reg, .wr_reject);

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic                  clk_sys, rstn, clk_en, rej;
   logic [3:0]            rd_a_idx, rd_b_idx;
   logic [15:0]           rd_a_data, rd_b_data, dflt, fp, sp, fv;
   wra_pkg::wra_wr_t      wr;
   wra_pkg::wra_mac_ops_t mac_ops;
   wra_pkg::wra_pf_t      pf_ptrs;
   int                    bad_count, cmp_count;
   wra_cpu_model wra_cpu_model_inst (.clk_sys, .wr, .mulf_file_val(fv));
   wra_regfile wra_regfile_inst (.clk_sys, .rstn, .clk_en, .wr, .mulf_file_val(fv), .rd_a_idx,
      .rd_b_idx, .rd_a_data, .rd_b_data, .default_work_register(dflt), .mac_ops, .pf_ptrs,
      .frame_pointer_reg(fp), .stack_pointer_reg(sp), .wr_reject(rej));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic close_out();
      if (bad_count == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out
   // #1 lets the take edge's updates land before anything is sampled
   task automatic go(input wra_pkg::wra_op_t o, input logic b, input logic [3:0] d,
                     input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] f);
      wra_cpu_model_inst.issue(o, b, d, lo, hi, f);
      #1;
   endtask : go
   task automatic rd(input logic [3:0] a, input logic [15:0] ea, input logic [3:0] b,
                     input logic [15:0] eb);
      @(posedge clk_sys);
      rd_a_idx <= a;
      rd_b_idx <= b;
      @(posedge clk_sys);
      #1;
      chk(rd_a_data, ea);
      chk(rd_b_data, eb);
   endtask : rd
   task automatic t_mul();
      go(wra_pkg::WRA_OP_DIV, 0, 0, 16'h1111, 16'h2222, 0);
      rd(4'h1, 16'h2222, 4'h0, 16'h1111);
      go(wra_pkg::WRA_OP_FILE_WR, 0, 4'h9, 16'h7705, 0, 0);
      chk(dflt, 16'h7705);
      go(wra_pkg::WRA_OP_MULF_WORD, 0, 0, 0, 0, 16'h1255);
      rd(4'h2, 16'hdea9, 4'h3, 16'h0885);
      go(wra_pkg::WRA_OP_MULF_BYTE, 1, 0, 0, 0, 16'h1255);
      rd(4'h2, 16'h01a9, 4'h3, 16'h0885);
   endtask : t_mul
   task automatic t_byte();
      go(wra_pkg::WRA_OP_FILE_WR, 1, 0, 16'h12ab, 0, 0);
      chk(dflt, 16'h77ab);
      go(wra_pkg::WRA_OP_MOVF_WR, 1, 4'h3, 16'h0055, 0, 0);
      chk({15'h0, rej}, 16'h0001);
      go(wra_pkg::WRA_OP_MOVF_WR, 1, 0, 16'h3344, 0, 0);
      chk(dflt, 16'h7744);
      go(wra_pkg::WRA_OP_MOVF_WR, 0, 4'h5, 16'hbeef, 0, 0);
      rd(4'h5, 16'hbeef, 4'h3, 16'h0885);
   endtask : t_byte
   task automatic t_roles();
      go(wra_pkg::WRA_OP_FRAME, 0, 0, 16'h0800, 16'h0810, 0);
      chk(fp, 16'h0800);
      go(wra_pkg::WRA_OP_STACK, 0, 0, 16'h0812, 0, 0);
      chk(sp, 16'h0812);
      go(wra_pkg::WRA_OP_WRITE, 0, 4'h4, 16'h1234, 0, 0);
      chk(mac_ops.op0, 16'h1234);
      go(wra_pkg::WRA_OP_WRITE, 0, 4'ha, 16'h2000, 0, 0);
      chk(pf_ptrs.y0, 16'h2000);
      go(wra_pkg::WRA_OP_MAC_WB, 0, 0, 16'h7777, 0, 0);
      rd(4'hd, 16'h7777, 4'he, 16'h0800);
      go(wra_pkg::WRA_OP_MUL_PAIR, 0, 4'hf, 16'haaaa, 16'h5555, 0);
      rd(4'he, 16'haaaa, 4'hf, 16'h5555);
   endtask : t_roles
   task automatic t_all();
      for (int i = 0; i < 16; i++) begin
         go(wra_pkg::WRA_OP_WRITE, 0, 4'(i), {4'(i), 8'h5a, 4'(i)}, 0, 0);
      end
      chk(mac_ops.op1, 16'h55a5);
      chk(mac_ops.op2, 16'h65a6);
      chk(mac_ops.op3, 16'h75a7);
      chk(pf_ptrs.x0, 16'h85a8);
      chk(pf_ptrs.x1, 16'h95a9);
      chk(pf_ptrs.y1, 16'hb5ab);
      chk(pf_ptrs.offset, 16'hc5ac);
      chk(fp, 16'he5ae);
      chk(sp, 16'hf5af);
      for (int i = 0; i < 8; i++) begin
         rd(4'(i), {4'(i), 8'h5a, 4'(i)}, 4'(i + 8), {4'(i + 8), 8'h5a, 4'(i + 8)});
      end
   endtask : t_all
   task automatic t_freeze();
      @(posedge clk_sys);
      clk_en <= 0;
      go(wra_pkg::WRA_OP_WRITE, 0, 4'h0, 16'hc0de, 0, 0);
      chk(dflt, 16'h05a0);
      @(posedge clk_sys);
      clk_en <= 1;
      go(wra_pkg::WRA_OP_FILE_WR, 0, 0, 16'hc0de, 0, 0);
      chk(dflt, 16'hc0de);
   endtask : t_freeze
   task automatic t_reset();
      @(posedge clk_sys);
      rstn <= 0;
      repeat (2) @(posedge clk_sys);
      rstn <= 1;
      #1;
      chk(dflt, 16'h0000);
      chk(sp, 16'h0000);
      go(wra_pkg::WRA_OP_DIV, 0, 0, 16'h0042, 16'h0007, 0);
      rd(4'h1, 16'h0007, 4'h2, 16'h0000);
   endtask : t_reset
   initial begin
      clk_sys = 0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (2000) @(posedge clk_sys);
      bad_count++;
      close_out();
   end
   initial begin
      {rstn, rd_a_idx, rd_b_idx, bad_count, cmp_count} = '0;
      clk_en = 1;
      repeat (5) @(posedge clk_sys);
      rstn <= 1;
      t_mul();
      t_byte();
      t_roles();
      t_all();
      t_freeze();
      t_reset();
      close_out();
   end
endmodule : testbench
